// ---- hw/pdhrp_pkg.sv ----
// pdhrp_pkg: constants and types for the palette dac host register port.
// assumes one 50 MHz clock and a synchronous active-high reset.
package pdhrp_pkg;

    // direct register selects
    localparam logic [2:0] SEL_PAL_WADDR = 3'h0;
    localparam logic [2:0] SEL_PAL_DATA = 3'h1;
    localparam logic [2:0] SEL_PIX_MASK = 3'h2;
    localparam logic [2:0] SEL_PAL_RADDR = 3'h3;
    localparam logic [2:0] SEL_IDX_LOW = 3'h4;
    localparam logic [2:0] SEL_IDX_HIGH = 3'h5;
    localparam logic [2:0] SEL_IDX_DATA = 3'h6;
    localparam logic [2:0] SEL_IDX_CTRL = 3'h7;

    // indexed register locations
    localparam logic [10:0] IDX_CUR2_RED = 11'h043;
    localparam logic [10:0] IDX_CUR2_GREEN = 11'h044;
    localparam logic [10:0] IDX_CUR2_BLUE = 11'h045;
    localparam logic [10:0] IDX_CUR3_RED = 11'h046;
    localparam logic [10:0] IDX_CUR3_GREEN = 11'h047;
    localparam logic [10:0] IDX_CUR3_BLUE = 11'h048;
    localparam logic [10:0] IDX_EDGE_RED = 11'h060;
    localparam logic [10:0] IDX_EDGE_GREEN = 11'h061;
    localparam logic [10:0] IDX_EDGE_BLUE = 11'h062;
    localparam logic [10:0] IDX_KEY_VALUE = 11'h068;
    localparam logic [10:0] IDX_KEY_MASK = 11'h06c;
    localparam logic [10:0] IDX_MISC1 = 11'h070;
    localparam logic [10:0] IDX_MISC2 = 11'h071;
    localparam logic [10:0] IDX_MISC3 = 11'h072;
    localparam logic [10:0] IDX_KEY_DBUF = 11'h078;
    localparam logic [10:0] IDX_SENSE = 11'h082;
    localparam logic [10:0] IDX_SIG_STATUS = 11'h083;
    localparam logic [10:0] IDX_SIG_RED = 11'h084;
    localparam logic [10:0] IDX_SIG_GREEN = 11'h086;
    localparam logic [10:0] IDX_SIG_BLUE = 11'h088;
    localparam logic [10:0] IDX_PLL_POST = 11'h08c;
    localparam logic [10:0] IDX_PLL_CHARGE = 11'h08d;
    localparam logic [10:0] IDX_PLL_VCO = 11'h08e;
    localparam logic [10:0] IDX_PLL_REF = 11'h08f;
    localparam logic [10:0] IDX_PMASK_LOW = 11'h090;
    localparam logic [10:0] IDX_PMASK_HIGH = 11'h091;
    localparam logic [10:0] IDX_SHAPE_FIRST = 11'h100;
    localparam logic [10:0] IDX_SHAPE_LAST = 11'h4ff;

    // storage slots of the writable indexed registers
    localparam int NUM_SLOTS = 17;
    localparam logic [4:0] SLOT_MISC1 = 5'h0c;
    localparam logic [4:0] SLOT_MISC2 = 5'h0d;
    localparam logic [4:0] SLOT_PMASK_LOW = 5'h0f;
    localparam logic [4:0] SLOT_PMASK_HIGH = 5'h10;
    localparam logic [4:0] SLOT_NONE = 5'h1f;

    // values after reset and fixed read-only values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PLL_POST_VALUE = 8'h00;
    localparam logic [7:0] PLL_CHARGE_VALUE = 8'h00;
    localparam logic [7:0] PLL_VCO_VALUE = 8'h05;
    localparam logic [7:0] PLL_REF_VALUE = 8'h05;

    // field positions
    localparam int MISC1_SIG_EN_BIT = 7;
    localparam int MISC1_PMASK_EN_BIT = 6;
    localparam int MISC1_RFMT_BIT = 5;
    localparam int MISC2_COLDEPTH_BIT = 2;
    localparam int MISC2_PORT_SEL_BIT = 0;
    localparam int IDXCTL_AUTO_BIT = 0;

    // palette access state codes
    localparam logic [1:0] ACC_WRITE = 2'h0;
    localparam logic [1:0] ACC_READ = 2'h3;

    // colour component sequencer, one-hot
    typedef enum logic [2:0] {
        COMP_RED = 3'b001,
        COMP_GREEN = 3'b010,
        COMP_BLUE = 3'b100
    } pdhrp_comp_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pdhrp_rgb_t;

    // one write request towards the palette and pointer shape memories
    typedef struct packed {
        logic pal_we;
        pdhrp_comp_t pal_comp;
        logic [7:0] pal_addr;
        logic shape_we;
        logic [9:0] shape_addr;
        logic [7:0] data;
    } pdhrp_mem_wr_t;

    // whole state of the register port
    typedef struct packed {
        logic [1:0] rd_sync;
        logic [1:0] wr_sync;
        logic [1:0] vblank_sync;
        logic [1:0] sense_sync;
        logic [2:0] sel_s1;
        logic [2:0] sel_s2;
        logic [7:0] din_s1;
        logic [7:0] din_s2;
        logic rd_prev;
        logic wr_prev;
        logic vblank_prev;
        logic [7:0] wr_addr;
        pdhrp_comp_t wr_comp;
        logic [7:0] rd_addr;
        pdhrp_comp_t rd_comp;
        logic [1:0] palette_access_state;
        logic [7:0] pix_mask;
        logic [10:0] index;
        logic auto_inc;
        logic [NUM_SLOTS-1:0][7:0] regs;
        logic sig_run;
        pdhrp_rgb_t sig;
        logic [7:0] dout;
        logic doe;
        pdhrp_mem_wr_t mem_wr;
    } pdhrp_state_t;

endpackage

// ---- hw/pdhrp_mem.sv ----
// pdhrp_mem: palette rams and pointer shape array with registered reads.
// assumes all ports on the same clock as the register port.
`timescale 1ns/1ps
`default_nettype none
module pdhrp_mem (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire pdhrp_pkg::pdhrp_mem_wr_t wr_i,
    input wire logic [7:0] pal_raddr_i,
    input wire pdhrp_pkg::pdhrp_comp_t pal_rcomp_i,
    output logic [7:0] pal_q_o,
    input wire logic [9:0] shape_raddr_i,
    output logic [7:0] shape_q_o,
    input wire logic [7:0] pixel_index_i,
    output pdhrp_pkg::pdhrp_rgb_t pixel_colour_o
);
    logic [7:0] pal_red [0:255];
    logic [7:0] pal_green [0:255];
    logic [7:0] pal_blue [0:255];
    logic [7:0] shape [0:1023];

    // memory writes, one component per request
    always_ff @(posedge ref_clk_i) begin
        if (wr_i.pal_we && wr_i.pal_comp == pdhrp_pkg::COMP_RED) begin
            pal_red[wr_i.pal_addr] <= wr_i.data;
        end
        if (wr_i.pal_we && wr_i.pal_comp == pdhrp_pkg::COMP_GREEN) begin
            pal_green[wr_i.pal_addr] <= wr_i.data;
        end
        if (wr_i.pal_we && wr_i.pal_comp == pdhrp_pkg::COMP_BLUE) begin
            pal_blue[wr_i.pal_addr] <= wr_i.data;
        end
        if (wr_i.shape_we) begin
            shape[wr_i.shape_addr] <= wr_i.data;
        end
    end

    // registered reads for host and pixel lookup
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pal_q_o <= 8'h00;
            shape_q_o <= 8'h00;
            pixel_colour_o <= '0;
        end else begin
            case (pal_rcomp_i)
                pdhrp_pkg::COMP_RED: pal_q_o <= pal_red[pal_raddr_i];
                pdhrp_pkg::COMP_GREEN: pal_q_o <= pal_green[pal_raddr_i];
                pdhrp_pkg::COMP_BLUE: pal_q_o <= pal_blue[pal_raddr_i];
                default: pal_q_o <= 8'h00;
            endcase
            shape_q_o <= shape[shape_raddr_i];
            // one index drives all three palettes
            pixel_colour_o.red <= pal_red[pixel_index_i];
            pixel_colour_o.green <= pal_green[pixel_index_i];
            pixel_colour_o.blue <= pal_blue[pixel_index_i];
        end
    end
endmodule // pdhrp_mem
`default_nettype wire

// ---- hw/pdhrp_top.sv ----
// pdhrp_top: microprocessor register port of a palette dac.
// assumes host strobes and video timing pins are asynchronous to ref_clk_i;
// pixel inputs arrive already on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pdhrp_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] register_select_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic vblank_i,
    input wire logic sense_i,
    input wire logic [7:0] vga_pixel_i,
    input wire logic [15:0] vram_pixel_i,
    output pdhrp_pkg::pdhrp_rgb_t pixel_colour_o
);
    pdhrp_pkg::pdhrp_state_t s;
    pdhrp_pkg::pdhrp_state_t next_s;
    logic [7:0] pal_q;
    logic [7:0] shape_q;
    logic [7:0] pixel_index;
    logic [9:0] shape_raddr;

    // next component in the red, green, blue cycle
    function automatic pdhrp_pkg::pdhrp_comp_t next_comp(input pdhrp_pkg::pdhrp_comp_t c);
        case (c)
            pdhrp_pkg::COMP_RED: next_comp = pdhrp_pkg::COMP_GREEN;
            pdhrp_pkg::COMP_GREEN: next_comp = pdhrp_pkg::COMP_BLUE;
            default: next_comp = pdhrp_pkg::COMP_RED;
        endcase
    endfunction

    // storage slot of a writable indexed location
    function automatic logic [4:0] slot_of(input logic [10:0] idx);
        case (idx)
            pdhrp_pkg::IDX_CUR2_RED: slot_of = 5'h00;
            pdhrp_pkg::IDX_CUR2_GREEN: slot_of = 5'h01;
            pdhrp_pkg::IDX_CUR2_BLUE: slot_of = 5'h02;
            pdhrp_pkg::IDX_CUR3_RED: slot_of = 5'h03;
            pdhrp_pkg::IDX_CUR3_GREEN: slot_of = 5'h04;
            pdhrp_pkg::IDX_CUR3_BLUE: slot_of = 5'h05;
            pdhrp_pkg::IDX_EDGE_RED: slot_of = 5'h06;
            pdhrp_pkg::IDX_EDGE_GREEN: slot_of = 5'h07;
            pdhrp_pkg::IDX_EDGE_BLUE: slot_of = 5'h08;
            pdhrp_pkg::IDX_KEY_VALUE: slot_of = 5'h09;
            pdhrp_pkg::IDX_KEY_MASK: slot_of = 5'h0a;
            pdhrp_pkg::IDX_MISC1: slot_of = pdhrp_pkg::SLOT_MISC1;
            pdhrp_pkg::IDX_MISC2: slot_of = pdhrp_pkg::SLOT_MISC2;
            pdhrp_pkg::IDX_MISC3: slot_of = 5'h0e;
            pdhrp_pkg::IDX_KEY_DBUF: slot_of = 5'h0b;
            pdhrp_pkg::IDX_PMASK_LOW: slot_of = pdhrp_pkg::SLOT_PMASK_LOW;
            pdhrp_pkg::IDX_PMASK_HIGH: slot_of = pdhrp_pkg::SLOT_PMASK_HIGH;
            default: slot_of = pdhrp_pkg::SLOT_NONE;
        endcase
    endfunction

    // true inside the pointer shape array window
    function automatic logic in_shape(input logic [10:0] idx);
        in_shape = (idx >= pdhrp_pkg::IDX_SHAPE_FIRST) && (idx <= pdhrp_pkg::IDX_SHAPE_LAST);
    endfunction

    // one step of an 8-bit multiple-input signature register
    function automatic logic [7:0] sig_step(input logic [7:0] acc, input logic [7:0] din);
        sig_step = {acc[6:0], acc[7] ^ acc[5] ^ acc[4] ^ acc[3]} ^ din;
    endfunction

    pdhrp_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(s.mem_wr),
        .pal_raddr_i(s.rd_addr),
        .pal_rcomp_i(s.rd_comp),
        .pal_q_o(pal_q),
        .shape_raddr_i(shape_raddr),
        .shape_q_o(shape_q),
        .pixel_index_i(pixel_index),
        .pixel_colour_o(pixel_colour_o)
    );

    // pointer shape read address follows the index
    always_comb begin
        shape_raddr = 10'(s.index - pdhrp_pkg::IDX_SHAPE_FIRST);
    end

    // pixel path: optional port mask, then the pixel mask
    always_comb begin
        logic [15:0] port_pix;
        logic [7:0] raw_index;
        port_pix = vram_pixel_i;
        raw_index = vga_pixel_i;
        if (s.regs[pdhrp_pkg::SLOT_MISC2][pdhrp_pkg::MISC2_PORT_SEL_BIT]) begin
            if (s.regs[pdhrp_pkg::SLOT_MISC1][pdhrp_pkg::MISC1_PMASK_EN_BIT]) begin
                port_pix = vram_pixel_i & {s.regs[pdhrp_pkg::SLOT_PMASK_HIGH],
                                           s.regs[pdhrp_pkg::SLOT_PMASK_LOW]};
            end
            raw_index = port_pix[7:0];
        end
        pixel_index = raw_index & s.pix_mask;
    end

    // next state of the whole port
    always_comb begin
        logic rd_fall;
        logic wr_rise;
        logic frame_start;
        logic six_bit;
        logic [4:0] slot;
        logic [7:0] rdata;
        logic [7:0] idata;
        rd_fall = 1'b0;
        wr_rise = 1'b0;
        frame_start = 1'b0;
        six_bit = 1'b0;
        slot = pdhrp_pkg::SLOT_NONE;
        rdata = 8'h00;
        idata = 8'h00;
        next_s = s;
        next_s.mem_wr.pal_we = 1'b0;
        next_s.mem_wr.shape_we = 1'b0;

        // pin synchronisers, second stage only is used
        next_s.rd_sync = {s.rd_sync[0], host_rd_n_i};
        next_s.wr_sync = {s.wr_sync[0], host_wr_n_i};
        next_s.vblank_sync = {s.vblank_sync[0], vblank_i};
        next_s.sense_sync = {s.sense_sync[0], sense_i};
        next_s.sel_s1 = register_select_i;
        next_s.sel_s2 = s.sel_s1;
        next_s.din_s1 = host_data_i;
        next_s.din_s2 = s.din_s1;
        next_s.rd_prev = s.rd_sync[1];
        next_s.wr_prev = s.wr_sync[1];
        next_s.vblank_prev = s.vblank_sync[1];
        rd_fall = s.rd_prev & ~s.rd_sync[1];
        wr_rise = ~s.wr_prev & s.wr_sync[1];
        frame_start = s.vblank_prev & ~s.vblank_sync[1];
        six_bit = ~s.regs[pdhrp_pkg::SLOT_MISC2][pdhrp_pkg::MISC2_COLDEPTH_BIT];
        slot = slot_of(s.index);

        // indexed read data
        if (slot != pdhrp_pkg::SLOT_NONE) begin
            idata = s.regs[slot];
        end else if (in_shape(s.index)) begin
            idata = shape_q;
        end else begin
            case (s.index)
                pdhrp_pkg::IDX_SENSE: idata = {7'h00, s.sense_sync[1]};
                pdhrp_pkg::IDX_SIG_STATUS: idata = {7'h00, s.sig_run};
                pdhrp_pkg::IDX_SIG_RED: idata = s.sig.red;
                pdhrp_pkg::IDX_SIG_GREEN: idata = s.sig.green;
                pdhrp_pkg::IDX_SIG_BLUE: idata = s.sig.blue;
                pdhrp_pkg::IDX_PLL_POST: idata = pdhrp_pkg::PLL_POST_VALUE;
                pdhrp_pkg::IDX_PLL_CHARGE: idata = pdhrp_pkg::PLL_CHARGE_VALUE;
                pdhrp_pkg::IDX_PLL_VCO: idata = pdhrp_pkg::PLL_VCO_VALUE;
                pdhrp_pkg::IDX_PLL_REF: idata = pdhrp_pkg::PLL_REF_VALUE;
                default: idata = 8'h00;
            endcase
        end

        // direct read data
        case (s.sel_s2)
            pdhrp_pkg::SEL_PAL_WADDR: rdata = s.wr_addr;
            pdhrp_pkg::SEL_PAL_DATA: rdata = six_bit ? {2'b00, pal_q[7:2]} : pal_q;
            pdhrp_pkg::SEL_PIX_MASK: rdata = s.pix_mask;
            pdhrp_pkg::SEL_PAL_RADDR: begin
                if (s.regs[pdhrp_pkg::SLOT_MISC1][pdhrp_pkg::MISC1_RFMT_BIT]) begin
                    rdata = {6'h00, s.palette_access_state};
                end else begin
                    rdata = s.rd_addr;
                end
            end
            pdhrp_pkg::SEL_IDX_LOW: rdata = s.index[7:0];
            pdhrp_pkg::SEL_IDX_HIGH: rdata = {5'h00, s.index[10:8]};
            pdhrp_pkg::SEL_IDX_DATA: rdata = idata;
            pdhrp_pkg::SEL_IDX_CTRL: rdata = {7'h00, s.auto_inc};
            default: rdata = 8'h00;
        endcase

        // read strobe: drive bus, advance read pointers
        next_s.doe = ~s.rd_sync[1];
        if (rd_fall) begin
            next_s.dout = rdata;
            if (s.sel_s2 == pdhrp_pkg::SEL_PAL_DATA) begin
                next_s.rd_comp = next_comp(s.rd_comp);
                if (s.rd_comp == pdhrp_pkg::COMP_BLUE) begin
                    next_s.rd_addr = s.rd_addr + 8'h01;
                end
            end
            if (s.sel_s2 == pdhrp_pkg::SEL_IDX_DATA && s.auto_inc) begin
                next_s.index = s.index + 11'h001;
            end
        end

        // write strobe, taken at its rising edge
        if (wr_rise) begin
            case (s.sel_s2)
                pdhrp_pkg::SEL_PAL_WADDR: begin
                    next_s.wr_addr = s.din_s2;
                    next_s.wr_comp = pdhrp_pkg::COMP_RED;
                    next_s.palette_access_state = pdhrp_pkg::ACC_WRITE;
                end
                pdhrp_pkg::SEL_PAL_DATA: begin
                    next_s.mem_wr.pal_we = 1'b1;
                    next_s.mem_wr.pal_comp = s.wr_comp;
                    next_s.mem_wr.pal_addr = s.wr_addr;
                    if (six_bit) begin
                        next_s.mem_wr.data = {s.din_s2[5:0], 2'b00};
                    end else begin
                        next_s.mem_wr.data = s.din_s2;
                    end
                    next_s.wr_comp = next_comp(s.wr_comp);
                    if (s.wr_comp == pdhrp_pkg::COMP_BLUE) begin
                        next_s.wr_addr = s.wr_addr + 8'h01;
                    end
                end
                pdhrp_pkg::SEL_PIX_MASK: next_s.pix_mask = s.din_s2;
                pdhrp_pkg::SEL_PAL_RADDR: begin
                    next_s.rd_addr = s.din_s2;
                    next_s.rd_comp = pdhrp_pkg::COMP_RED;
                    next_s.palette_access_state = pdhrp_pkg::ACC_READ;
                end
                pdhrp_pkg::SEL_IDX_LOW: next_s.index[7:0] = s.din_s2;
                pdhrp_pkg::SEL_IDX_HIGH: next_s.index[10:8] = s.din_s2[2:0];
                pdhrp_pkg::SEL_IDX_DATA: begin
                    if (slot != pdhrp_pkg::SLOT_NONE) begin
                        next_s.regs[slot] = s.din_s2;
                    end else if (in_shape(s.index)) begin
                        next_s.mem_wr.shape_we = 1'b1;
                        next_s.mem_wr.shape_addr = shape_raddr;
                        next_s.mem_wr.data = s.din_s2;
                    end
                    // read-only and reserved locations keep their state
                    if (s.auto_inc) begin
                        next_s.index = s.index + 11'h001;
                    end
                end
                pdhrp_pkg::SEL_IDX_CTRL: next_s.auto_inc = s.din_s2[pdhrp_pkg::IDXCTL_AUTO_BIT];
                default: next_s.auto_inc = s.auto_inc;
            endcase
        end

        // signature start and stop only at frame start
        if (s.sig_run) begin
            next_s.sig.red = sig_step(s.sig.red, pixel_colour_o.red);
            next_s.sig.green = sig_step(s.sig.green, pixel_colour_o.green);
            next_s.sig.blue = sig_step(s.sig.blue, pixel_colour_o.blue);
        end
        if (frame_start) begin
            next_s.sig_run = s.regs[pdhrp_pkg::SLOT_MISC1][pdhrp_pkg::MISC1_SIG_EN_BIT];
            if (!s.sig_run && s.regs[pdhrp_pkg::SLOT_MISC1][pdhrp_pkg::MISC1_SIG_EN_BIT]) begin
                next_s.sig = '0; // fresh signature per run
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.rd_sync <= 2'b11;
            s.wr_sync <= 2'b11;
            s.rd_prev <= 1'b1;
            s.wr_prev <= 1'b1;
            s.wr_comp <= pdhrp_pkg::COMP_RED;
            s.rd_comp <= pdhrp_pkg::COMP_RED;
            s.mem_wr.pal_comp <= pdhrp_pkg::COMP_RED;
            s.pix_mask <= 8'hff;
            s.regs <= {pdhrp_pkg::NUM_SLOTS{pdhrp_pkg::REG_RESET}};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign host_data_o = s.dout;
    assign host_data_oe_o = s.doe;
endmodule // pdhrp_top
`default_nettype wire

// ---- test/pdhrp_chk.sv ----
// pdhrp_chk: bus timing checks at the register port pins.
// assumes host strobes change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module pdhrp_chk (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic host_rd_n_i,
    input wire logic [7:0] host_data_o,
    input wire logic host_data_oe_o,
    input wire pdhrp_pkg::pdhrp_rgb_t pixel_colour_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // read strobe turns the bus driver on and off
    a_oe_on_read: assert property ($fell(host_rd_n_i) |-> ##[3:5] host_data_oe_o)
        else $error("bus not driven after read strobe");
    a_oe_long_read: assert property (!host_rd_n_i [*6] |-> host_data_oe_o)
        else $error("bus dropped during read");
    a_oe_idle_off: assert property (host_rd_n_i [*6] |-> !host_data_oe_o)
        else $error("bus driven without read");
    a_oe_has_cause: assert property ($rose(host_data_oe_o) |-> !host_rd_n_i && !$past(host_rd_n_i, 2))
        else $error("bus driven too early");
    a_oe_min_width: assert property ($rose(host_data_oe_o) |-> host_data_oe_o [*3])
        else $error("bus drive too short");
    // read data moves only when a read is answered
    a_data_on_read: assert property ($changed(host_data_o) |-> $rose(host_data_oe_o))
        else $error("read data changed outside a read");
    a_data_after: assert property (host_rd_n_i [*8] |=> $stable(host_data_o))
        else $error("read data not held");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> host_data_o == 8'h00 && !host_data_oe_o && pixel_colour_o == 24'h00_0000)
        else $error("outputs not cleared by reset");
endmodule // pdhrp_chk
bind pdhrp_top pdhrp_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_rd_n_i(host_rd_n_i),
    .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o), .pixel_colour_o(pixel_colour_o));
`default_nettype wire

// ---- test/pdhrp_host.sv ----
// pdhrp_host: host microprocessor model with read and write cycles.
// assumes a free-running clock; drives on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module pdhrp_host (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic oe_i,
    output logic [2:0] sel_o,
    output logic [7:0] data_o,
    output logic rd_n_o,
    output logic wr_n_o
);
    // idle bus at time zero
    initial begin
        sel_o = 3'h0;
        data_o = 8'h00;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // select and data held around the strobe; never relies on index past top
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        cyc(1);
        sel_o = s;
        data_o = d;
        cyc(4);
        wr_n_o = 1'b0;
        cyc(4);
        wr_n_o = 1'b1;
        cyc(4);
        data_o = ~d; // released bus shows no stale value
        cyc(1);
    endtask
    task automatic rd(input logic [2:0] s, output logic [7:0] q, output logic oe);
        cyc(1);
        sel_o = s;
        cyc(4);
        rd_n_o = 1'b0;
        cyc(6);
        q = rdata_i;
        oe = oe_i;
        rd_n_o = 1'b1;
        cyc(5);
    endtask
endmodule // pdhrp_host
`default_nettype wire

// ---- test/test_palette_dac_host_register_port.sv ----
// test_palette_dac_host_register_port: register port scenarios.
// assumes pdhrp_host supplies the bus cycles.
`timescale 1ns/1ps
`default_nettype none
module test_palette_dac_host_register_port;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic vblank_i = 1'b0;
    logic [7:0] vga_pixel_i = 8'h00;
    logic [15:0] vram_pixel_i = 16'h0000;
    logic [2:0] sel;
    logic [7:0] din, dout, q;
    logic rd_n, wr_n;
    logic oe, oe_seen;
    logic sense = 1'b0;
    pdhrp_pkg::pdhrp_rgb_t colour;
    int err_total = 0;
    int n_checks = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    pdhrp_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .register_select_i(sel), .host_data_i(din),
        .host_data_o(dout), .host_data_oe_o(oe), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .vblank_i(vblank_i),
        .sense_i(sense), .vga_pixel_i(vga_pixel_i), .vram_pixel_i(vram_pixel_i), .pixel_colour_o(colour));
    pdhrp_host host (.ref_clk_i(ref_clk_i), .rdata_i(dout), .oe_i(oe), .sel_o(sel), .data_o(din),
        .rd_n_o(rd_n), .wr_n_o(wr_n));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [2:0] s, input logic [7:0] e);
        host.rd(s, q, oe_seen);
        chk({16'h0000, q}, {16'h0000, e});
        chk({23'h00_0000, oe_seen}, 24'h00_0001);
        chk({23'h00_0000, oe}, 24'h00_0000);
    endtask
    // point the index, then write or read there
    task automatic ixw(input logic [10:0] a, input logic [7:0] d);
        host.wr(pdhrp_pkg::SEL_IDX_LOW, a[7:0]);
        host.wr(pdhrp_pkg::SEL_IDX_HIGH, {5'h00, a[10:8]});
        host.wr(pdhrp_pkg::SEL_IDX_DATA, d);
    endtask
    task automatic ixr(input logic [10:0] a, input logic [7:0] e);
        host.wr(pdhrp_pkg::SEL_IDX_LOW, a[7:0]);
        host.wr(pdhrp_pkg::SEL_IDX_HIGH, {5'h00, a[10:8]});
        rdc(pdhrp_pkg::SEL_IDX_DATA, e);
    endtask
    // read one colour triple from a read address
    task automatic pal(input logic [7:0] a, input logic [23:0] e);
        host.wr(pdhrp_pkg::SEL_PAL_RADDR, a);
        for (int i = 2; i >= 0; i--) begin
            rdc(pdhrp_pkg::SEL_PAL_DATA, e[i*8 +: 8]);
        end
    endtask
    task automatic frame;
        vblank_i = 1'b1;
        host.cyc(4);
        vblank_i = 1'b0;
        host.cyc(6);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog against a hung sequence
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        err_total++;
        conclude();
    end
    initial begin
        host.cyc(6);
        rst_i = 1'b0;
        host.cyc(4);
        rdc(pdhrp_pkg::SEL_PIX_MASK, 8'hff);
        sense = 1'b1;
        ixr(pdhrp_pkg::IDX_SENSE, 8'h01);
        ixr(pdhrp_pkg::IDX_MISC1, 8'h00);
        host.wr(pdhrp_pkg::SEL_IDX_CTRL, 8'h01);
        ixw(pdhrp_pkg::IDX_MISC1, 8'h00);
        host.wr(pdhrp_pkg::SEL_IDX_DATA, 8'h04); // stepped to misc2, 8-bit depth
        rdc(pdhrp_pkg::SEL_IDX_LOW, 8'h72);
        host.wr(pdhrp_pkg::SEL_IDX_HIGH, 8'hff);
        rdc(pdhrp_pkg::SEL_IDX_HIGH, 8'h07);
        host.wr(pdhrp_pkg::SEL_IDX_CTRL, 8'h00);
        ixr(pdhrp_pkg::IDX_MISC2, 8'h04);
        rdc(pdhrp_pkg::SEL_IDX_DATA, 8'h04);
        ixw(pdhrp_pkg::IDX_PLL_REF, 8'haa);
        rdc(pdhrp_pkg::SEL_IDX_DATA, 8'h05);
        ixw(11'h049, 8'h5a);
        rdc(pdhrp_pkg::SEL_IDX_DATA, 8'h00);
        host.wr(pdhrp_pkg::SEL_PAL_WADDR, 8'h10);
        host.wr(pdhrp_pkg::SEL_PAL_DATA, 8'ha5);
        host.wr(pdhrp_pkg::SEL_PAL_DATA, 8'h3c);
        host.wr(pdhrp_pkg::SEL_PAL_DATA, 8'hff);
        pal(8'h10, 24'ha5_3cff);
        rdc(pdhrp_pkg::SEL_PAL_RADDR, 8'h11);
        ixw(pdhrp_pkg::IDX_MISC1, 8'h20);
        rdc(pdhrp_pkg::SEL_PAL_RADDR, 8'h03);
        host.wr(pdhrp_pkg::SEL_PAL_WADDR, 8'h20);
        rdc(pdhrp_pkg::SEL_PAL_RADDR, 8'h00);
        ixw(pdhrp_pkg::IDX_MISC2, 8'h00);
        host.wr(pdhrp_pkg::SEL_PAL_DATA, 8'hff);
        host.wr(pdhrp_pkg::SEL_PAL_DATA, 8'h81);
        host.wr(pdhrp_pkg::SEL_PAL_DATA, 8'h40);
        pal(8'h20, 24'h3f_0100);
        ixw(pdhrp_pkg::IDX_MISC2, 8'h04);
        pal(8'h20, 24'hfc_0400);
        host.wr(pdhrp_pkg::SEL_PIX_MASK, 8'h30);
        vga_pixel_i = 8'h1f;
        host.cyc(3);
        chk(colour, 24'ha5_3cff);
        host.wr(pdhrp_pkg::SEL_PIX_MASK, 8'hff);
        ixw(pdhrp_pkg::IDX_PMASK_LOW, 8'h30);
        ixw(pdhrp_pkg::IDX_MISC1, 8'h40);
        ixw(pdhrp_pkg::IDX_MISC2, 8'h05);
        vram_pixel_i = 16'h001f;
        host.cyc(3);
        chk(colour, 24'ha5_3cff);
        ixw(pdhrp_pkg::IDX_PMASK_HIGH, 8'hc3);
        ixr(pdhrp_pkg::IDX_PMASK_HIGH, 8'hc3);
        ixw(pdhrp_pkg::IDX_KEY_DBUF, 8'h5a);
        ixr(pdhrp_pkg::IDX_PMASK_LOW, 8'h30);
        ixr(pdhrp_pkg::IDX_KEY_DBUF, 8'h5a);
        ixw(pdhrp_pkg::IDX_MISC1, 8'h80);
        frame();
        ixr(pdhrp_pkg::IDX_SIG_STATUS, 8'h01);
        ixw(pdhrp_pkg::IDX_MISC1, 8'h00);
        ixr(pdhrp_pkg::IDX_SIG_STATUS, 8'h01);
        frame();
        rdc(pdhrp_pkg::SEL_IDX_DATA, 8'h00);
        conclude();
    end
endmodule // test_palette_dac_host_register_port
`default_nettype wire
